// ==== pcht_params.svh ====
// Constants for the configuration header tail: indices, field slices, resets and timer limits.
`ifndef PCHT_PARAMS_SVH
`define PCHT_PARAMS_SVH

// ************************************************************
// Dword indices of the configuration accesses (byte offset / 4)
// ************************************************************
`define PCHT_IDX_SUBSYS   6'h0B
`define PCHT_IDX_INTR     6'h0F
`define PCHT_IDX_TRDY     6'h10

// ************************************************************
// Field slices inside each configuration dword
// ************************************************************
`define PCHT_VENDOR_F     15:0
`define PCHT_SUBSYS_F     31:16
`define PCHT_LINE_F       7:0
`define PCHT_PIN_F        15:8
`define PCHT_BURST_F      23:16
`define PCHT_INTERVAL_F   31:24
`define PCHT_LIMIT_F      7:0
`define PCHT_FLAG_BIT     8
`define PCHT_FLAG_BE      1

// ************************************************************
// Reset and hardwired values
// ************************************************************
// Arbitrary neutral reset values for the two subsystem identifiers.
`define PCHT_VENDOR_RST   16'hA5A5
`define PCHT_SUBSYS_RST   16'h5A5A
`define PCHT_LINE_RST     8'h00
`define PCHT_PIN_VAL      8'h00
`define PCHT_BURST_VAL    8'h00
`define PCHT_INTERVAL_VAL 8'h00
`define PCHT_LIMIT_RST    8'h00
`define PCHT_WORD_ZERO    32'h0000_0000

// ************************************************************
// Timer constants
// ************************************************************
`define PCHT_LIMIT_OFF    8'h00
`define PCHT_COUNT_ONE    8'h01
`define PCHT_COUNT_MAX    8'hFF

`endif

// ==== pcht_pkg.sv ====
// Types shared by the configuration header tail and its TRDY timer.
package pcht_pkg;
    typedef logic [31:0] pcht_word_t;
    typedef logic [7:0]  pcht_byte_t;
    typedef logic [5:0]  pcht_idx_t;
    typedef logic [3:0]  pcht_be_t;

    // Wait state of the TRDY timer.
    typedef enum logic {
        PCHT_IDLE = 1'b0,
        PCHT_WAIT = 1'b1
    } pcht_wait_e;
endpackage

// ==== pcht_trdy_timer.sv ====
// TRDY wait timer for master data phases.
`timescale 1ns/10ps
`include "pcht_params.svh"

module pcht_trdy_timer (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // Programmed limit in PCI clocks, zero waits forever.
    input  wire pcht_pkg::pcht_byte_t limit,
    // Data phase control from the master engine.
    input  wire logic                 phase_start,
    input  wire logic                 phase_end,
    input  wire logic                 trdy_seen,
    // One-cycle pulse when the wait ran out.
    output logic                      expired
);

    // ************************************************************
    // Wait state and cycle counter
    // ************************************************************
    pcht_pkg::pcht_wait_e state_q;
    pcht_pkg::pcht_byte_t count_q;
    logic                 expired_q;
    logic                 hit;

    // The limit is reached on the limit-th waited cycle without TRDY.
    assign hit = (limit != `PCHT_LIMIT_OFF) && !trdy_seen
               && (count_q == limit - `PCHT_COUNT_ONE);

    // A new phase always restarts the wait, even while one is running.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= pcht_pkg::PCHT_IDLE;
        end else begin
            unique case (state_q)
                pcht_pkg::PCHT_IDLE: begin
                    if (phase_start) begin
                        state_q <= pcht_pkg::PCHT_WAIT;
                    end
                end
                pcht_pkg::PCHT_WAIT: begin
                    if (phase_start) begin
                        state_q <= pcht_pkg::PCHT_WAIT;
                    end else if (trdy_seen || phase_end || hit) begin
                        state_q <= pcht_pkg::PCHT_IDLE;
                    end
                end
            endcase
        end
    end

    // Counter saturates so that the unlimited mode never wraps into a false hit.
    always_ff @(posedge clk) begin
        if (sys_rst || phase_start) begin
            count_q <= `PCHT_LIMIT_OFF;
        end else if (state_q == pcht_pkg::PCHT_WAIT && !trdy_seen
                     && count_q != `PCHT_COUNT_MAX) begin
            count_q <= count_q + `PCHT_COUNT_ONE;
        end
    end

    // Expiry pulse is registered and one cycle after the last waited cycle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            expired_q <= 1'b0;
        end else begin
            expired_q <= (state_q == pcht_pkg::PCHT_WAIT) && hit
                       && !phase_start && !phase_end;
        end
    end

    // The port comes straight from the flop, so the master sees a clean pulse.
    assign expired = expired_q;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_NO_EXPIRE_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
        ($past(limit) == `PCHT_LIMIT_OFF) |-> !expired_q)
        else $error("Timer expired although the limit was zero.");

    AST_EXPIRE_AT_LIMIT: assert property (@(posedge clk) disable iff (sys_rst)
        expired_q |-> ($past(count_q) == $past(limit) - `PCHT_COUNT_ONE))
        else $error("Timer expired at a count other than the limit.");

    AST_RESTART: assert property (@(posedge clk) disable iff (sys_rst)
        phase_start |=> (count_q == `PCHT_LIMIT_OFF && state_q == pcht_pkg::PCHT_WAIT))
        else $error("New data phase did not restart the wait.");

endmodule

// ==== pcht_config_tail.sv ====
// Upper PCI configuration header fields and master TRDY timeout control.
`timescale 1ns/10ps
`include "pcht_params.svh"

module pcht_config_tail (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // Configuration cycle port.
    input  wire logic                 cfg_req,
    input  wire logic                 cfg_we,
    input  wire pcht_pkg::pcht_idx_t  cfg_index,
    input  wire pcht_pkg::pcht_be_t   cfg_be,
    input  wire pcht_pkg::pcht_word_t cfg_wdata,
    output logic                      cfg_ack,
    output pcht_pkg::pcht_word_t      cfg_rdata,
    // Master data phase control.
    input  wire logic                 mst_phase_start,
    input  wire logic                 mst_phase_end,
    input  wire logic                 mst_trdy_seen,
    output logic                      mst_timeout,
    // Configured values for the rest of the core.
    output pcht_pkg::pcht_byte_t      irq_route_line
);

    // ************************************************************
    // Byte-lane merge
    // ************************************************************
    // Writes touch only the enabled byte lanes; used by every writable word.
    function automatic pcht_pkg::pcht_word_t merge_lanes(
        input pcht_pkg::pcht_word_t old_w,
        input pcht_pkg::pcht_word_t new_w,
        input pcht_pkg::pcht_be_t   be
    );
        pcht_pkg::pcht_word_t res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ************************************************************
    // Register state
    // ************************************************************
    pcht_pkg::pcht_word_t subsys_q;
    pcht_pkg::pcht_byte_t line_q;
    pcht_pkg::pcht_byte_t limit_q;
    logic                 flag_q;
    logic                 ack_q;
    pcht_pkg::pcht_word_t rdata_q;
    pcht_pkg::pcht_word_t intr_word;
    pcht_pkg::pcht_word_t trdy_word;
    pcht_pkg::pcht_word_t wmerge_intr;
    pcht_pkg::pcht_word_t wmerge_trdy;
    logic                 wr_subsys;
    logic                 wr_intr;
    logic                 wr_trdy;
    logic                 expired;

    // Write strobes per addressed dword.
    assign wr_subsys = cfg_req && cfg_we && (cfg_index == `PCHT_IDX_SUBSYS);
    assign wr_intr   = cfg_req && cfg_we && (cfg_index == `PCHT_IDX_INTR);
    assign wr_trdy   = cfg_req && cfg_we && (cfg_index == `PCHT_IDX_TRDY);

    // Read views; hardwired bytes ignore writes.
    always_comb begin
        intr_word                  = `PCHT_WORD_ZERO;
        intr_word[`PCHT_LINE_F]    = line_q;
        intr_word[`PCHT_PIN_F]     = `PCHT_PIN_VAL;
        intr_word[`PCHT_BURST_F]    = `PCHT_BURST_VAL;
        intr_word[`PCHT_INTERVAL_F] = `PCHT_INTERVAL_VAL;
        trdy_word                  = `PCHT_WORD_ZERO;
        trdy_word[`PCHT_LIMIT_F]   = limit_q;
        trdy_word[`PCHT_FLAG_BIT]  = flag_q;
    end

    assign wmerge_intr = merge_lanes(intr_word, cfg_wdata, cfg_be);
    assign wmerge_trdy = merge_lanes(trdy_word, cfg_wdata, cfg_be);

    // Subsystem identifiers, both halves writable by lane.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            subsys_q <= {`PCHT_SUBSYS_RST, `PCHT_VENDOR_RST};
        end else if (wr_subsys) begin
            subsys_q <= merge_lanes(subsys_q, cfg_wdata, cfg_be);
        end
    end

    // Interrupt routing line is the only writable byte of its dword.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            line_q <= `PCHT_LINE_RST;
        end else if (wr_intr) begin
            line_q <= wmerge_intr[`PCHT_LINE_F];
        end
    end

    // TRDY wait limit; a change mid-phase takes effect on the next compare.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            limit_q <= `PCHT_LIMIT_RST;
        end else if (wr_trdy) begin
            limit_q <= wmerge_trdy[`PCHT_LIMIT_F];
        end
    end

    // Timeout status, write one to clear; a new expiry wins over the clear.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_q <= 1'b0;
        end else if (expired) begin
            flag_q <= 1'b1;
        end else if (wr_trdy && cfg_be[`PCHT_FLAG_BE] && cfg_wdata[`PCHT_FLAG_BIT]) begin
            flag_q <= 1'b0;
        end
    end

    // Registered answer; unmapped indices read as zero and drop writes.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_q   <= 1'b0;
            rdata_q <= `PCHT_WORD_ZERO;
        end else begin
            ack_q <= cfg_req;
            if (cfg_req && !cfg_we) begin
                unique case (cfg_index)
                    `PCHT_IDX_SUBSYS: rdata_q <= subsys_q;
                    `PCHT_IDX_INTR:   rdata_q <= intr_word;
                    `PCHT_IDX_TRDY:   rdata_q <= trdy_word;
                    default:          rdata_q <= `PCHT_WORD_ZERO;
                endcase
            end
        end
    end

    // ************************************************************
    // TRDY timer
    // ************************************************************
    pcht_trdy_timer u_timer (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .limit       (limit_q),
        .phase_start (mst_phase_start),
        .phase_end   (mst_phase_end),
        .trdy_seen   (mst_trdy_seen),
        .expired     (expired)
    );

    // The master engine ends the transaction on this pulse.
    assign mst_timeout    = expired;
    assign cfg_ack        = ack_q;
    assign cfg_rdata      = rdata_q;
    assign irq_route_line = line_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_VENDOR_WR: assert property (
        (wr_subsys && cfg_be[1:0] == 2'b11)
        |=> (subsys_q[`PCHT_VENDOR_F] == $past(cfg_wdata[`PCHT_VENDOR_F])))
        else $error("Subsystem vendor code did not take the write.");

    AST_SUBSYS_RD: assert property (
        (cfg_req && !cfg_we && cfg_index == `PCHT_IDX_SUBSYS)
        |=> (cfg_ack && cfg_rdata[`PCHT_SUBSYS_F] == subsys_q[`PCHT_SUBSYS_F]))
        else $error("Subsystem code read back wrong.");

    AST_LINE_RST: assert property (@(posedge clk) disable iff (1'b0)
        sys_rst |=> (line_q == `PCHT_LINE_RST))
        else $error("Interrupt routing line not cleared by reset.");

    AST_PIN_RD: assert property (
        (cfg_req && !cfg_we && cfg_index == `PCHT_IDX_INTR)
        |=> (cfg_rdata[`PCHT_PIN_F] == `PCHT_PIN_VAL))
        else $error("Interrupt pin byte read back wrong.");

    AST_BURST_RD: assert property (
        (cfg_req && !cfg_we && cfg_index == `PCHT_IDX_INTR)
        |=> (cfg_rdata[`PCHT_BURST_F] == `PCHT_BURST_VAL))
        else $error("Burst period byte read back wrong.");

    AST_INTERVAL_RD: assert property (
        (cfg_req && !cfg_we && cfg_index == `PCHT_IDX_INTR)
        |=> (cfg_rdata[`PCHT_INTERVAL_F] == `PCHT_INTERVAL_VAL))
        else $error("Bus access interval byte read back wrong.");

    AST_LIMIT_ONE: assert property (
        (limit_q == `PCHT_COUNT_ONE && mst_phase_start && !cfg_req)
        ##1 (!mst_trdy_seen && !mst_phase_start && !mst_phase_end) |=> mst_timeout)
        else $error("Limit of one clock did not expire after one waited clock.");

    AST_ZERO_FOREVER: assert property (
        (limit_q == `PCHT_LIMIT_OFF && !wr_trdy) |=> !mst_timeout)
        else $error("Timeout fired with the limit at zero.");

    AST_FLAG_SET: assert property (
        mst_timeout |=> flag_q)
        else $error("Expiry did not set the timeout status.");

    CV_EXPIRE: cover property (mst_timeout);
    CV_FLAG_CLEAR: cover property (flag_q ##1 !flag_q);
    CV_SUBSYS_WR: cover property (wr_subsys
        ##1 (cfg_req && !cfg_we && cfg_index == `PCHT_IDX_SUBSYS));
    CV_TRDY_OK: cover property (mst_phase_start ##[1:4] mst_trdy_seen);

endmodule

// ==== pcht_host_model.sv ====
// Behavioural PCI host issuing configuration cycles to the header tail.
`timescale 1ns/10ps

module pcht_host_model (
    // Clock.
    input  wire logic                 clk,
    // Configuration request lines driven toward the block.
    output logic                      cfg_req,
    output logic                      cfg_we,
    output pcht_pkg::pcht_idx_t       cfg_index,
    output pcht_pkg::pcht_be_t        cfg_be,
    output pcht_pkg::pcht_word_t      cfg_wdata,
    // Answer lines from the block.
    input  wire logic                 cfg_ack,
    input  wire pcht_pkg::pcht_word_t cfg_rdata
);
    // Idle request lines from time zero.
    initial begin
        cfg_req   = 1'b0;
        cfg_we    = 1'b0;
        cfg_index = 6'h00;
        cfg_be    = 4'h0;
        cfg_wdata = 32'h0000_0000;
    end

    // One access: a single-cycle request whose qualifiers stand until the answer is seen.
    task automatic access(input logic we, input pcht_pkg::pcht_idx_t idx,
                          input pcht_pkg::pcht_be_t be, input pcht_pkg::pcht_word_t wd,
                          output pcht_pkg::pcht_word_t rd, output logic ok);
        int n;
        ok = 1'b0;
        rd = 32'h0000_0000;
        @(posedge clk);
        cfg_req   <= 1'b1;
        cfg_we    <= we;
        cfg_index <= idx;
        cfg_be    <= be;
        cfg_wdata <= wd;
        @(posedge clk);
        // The block takes the request on this edge; a longer pulse would be a second access.
        cfg_req   <= 1'b0;
        for (n = 0; n < 4 && !ok; n++) begin
            @(posedge clk);
            if (cfg_ack === 1'b1) begin
                ok = 1'b1;
                rd = cfg_rdata;
            end
        end
        // Released lanes carry inverted junk so a stale value is never mistaken for data.
        cfg_be    <= ~be;
        cfg_wdata <= ~wd;
    endtask
endmodule

// ==== tb_pci_config_header_tail.sv ====
// Self-checking testbench for the configuration header tail.
`timescale 1ns/10ps

module tb_pci_config_header_tail;
    logic                 clk;
    logic                 sys_rst;
    logic                 cfg_req;
    logic                 cfg_we;
    logic                 cfg_ack;
    pcht_pkg::pcht_idx_t  cfg_index;
    pcht_pkg::pcht_be_t   cfg_be;
    pcht_pkg::pcht_word_t cfg_wdata;
    pcht_pkg::pcht_word_t cfg_rdata;
    pcht_pkg::pcht_word_t rd;
    logic                 mst_phase_start;
    logic                 mst_phase_end;
    logic                 mst_trdy_seen;
    logic                 mst_timeout;
    pcht_pkg::pcht_byte_t irq_route_line;
    int                   fail_count = 0;
    int                   compares = 0;

    pcht_config_tail dut_u (.clk(clk), .sys_rst(sys_rst), .cfg_req(cfg_req),
        .cfg_we(cfg_we), .cfg_index(cfg_index), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .mst_phase_start(mst_phase_start),
        .mst_phase_end(mst_phase_end), .mst_trdy_seen(mst_trdy_seen),
        .mst_timeout(mst_timeout), .irq_route_line(irq_route_line));

    pcht_host_model host_u (.clk(clk), .cfg_req(cfg_req), .cfg_we(cfg_we),
        .cfg_index(cfg_index), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));

    // 40 MHz clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string name, input pcht_pkg::pcht_word_t exp,
                       input pcht_pkg::pcht_word_t got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // A configuration access; a missing answer ends the run as a failure.
    task automatic cfg(input logic we, input pcht_pkg::pcht_idx_t idx,
                       input pcht_pkg::pcht_be_t be, input pcht_pkg::pcht_word_t wd);
        logic ok;
        host_u.access(we, idx, be, wd, rd, ok);
        if (ok !== 1'b1) begin
            fail_count++;
            $display("ERROR cfg_ack expected 1 seen 0");
            end_sim();
        end
    endtask

    // Programs a limit, runs one data phase with optional restart, TRDY or end cycle,
    // and checks the cycle of the timeout pulse counted from the start cycle (0 = none).
    task automatic tmr(input int lim, input int rs, input int ty, input int en,
                       input int span, input int exp);
        int k;
        int first;
        int cnt;
        first = 0;
        cnt = 0;
        cfg(1'b1, 6'h10, 4'h1, 32'(lim));
        @(posedge clk);
        mst_phase_start <= 1'b1;
        for (k = 1; k <= span; k++) begin
            @(posedge clk);
            mst_phase_start <= (k == rs);
            mst_trdy_seen   <= (k == ty);
            mst_phase_end   <= (k == en);
            #1;
            if (mst_timeout !== 1'b0) begin
                cnt++;
                if (first == 0) first = k;
            end
        end
        chk("timeout cycle", 32'(exp), 32'(first));
        chk("timeout pulses", (exp != 0) ? 32'h0000_0001 : 32'h0000_0000, 32'(cnt));
    endtask

    // Reset values of the subsystem and interrupt words and of the route line.
    task automatic t_reset();
        cfg(1'b0, 6'h0B, 4'h0, 32'h0000_0000);
        chk("subsystem word", 32'h5A5A_A5A5, rd);
        cfg(1'b0, 6'h0F, 4'h0, 32'h0000_0000);
        chk("interrupt word", 32'h0000_0000, rd);
        chk("route line", 32'h0000_0000, 32'(irq_route_line));
    endtask

    // Byte-lane writes, read-only bytes, an unmapped index and a reset in mid-run.
    task automatic t_regs();
        cfg(1'b1, 6'h0B, 4'hF, 32'h1234_5678);
        cfg(1'b0, 6'h0B, 4'h0, 32'h0000_0000);
        chk("subsystem full", 32'h1234_5678, rd);
        cfg(1'b1, 6'h0B, 4'h3, 32'hFFFF_0000);
        cfg(1'b0, 6'h0B, 4'h0, 32'h0000_0000);
        chk("vendor lanes", 32'h1234_0000, rd);
        cfg(1'b1, 6'h0F, 4'hF, 32'hFFFF_FFFF);
        cfg(1'b0, 6'h0F, 4'h0, 32'h0000_0000);
        chk("interrupt ro", 32'h0000_00FF, rd);
        chk("route line out", 32'h0000_00FF, 32'(irq_route_line));
        cfg(1'b1, 6'h01, 4'hF, 32'hFFFF_FFFF);
        cfg(1'b0, 6'h01, 4'h0, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        cfg(1'b0, 6'h0F, 4'h0, 32'h0000_0000);
        chk("line after reset", 32'h0000_0000, rd);
    endtask

    // Timeout counts, restart, TRDY and end cancelling, the status bit and zero limit.
    task automatic t_timer();
        cfg(1'b0, 6'h10, 4'h0, 32'h0000_0000);
        chk("limit reset", 32'h0000_0000, rd);
        tmr(1, 0, 0, 0, 6, 2);
        tmr(2, 0, 0, 0, 8, 3);
        cfg(1'b0, 6'h10, 4'h0, 32'h0000_0000);
        chk("status set", 32'h0000_0102, rd);
        cfg(1'b1, 6'h10, 4'h2, 32'h0000_0100);
        cfg(1'b0, 6'h10, 4'h0, 32'h0000_0000);
        chk("status clear", 32'h0000_0002, rd);
        tmr(2, 2, 0, 0, 10, 5);
        tmr(2, 0, 2, 0, 8, 0);
        tmr(3, 0, 0, 1, 8, 0);
        tmr(255, 0, 0, 0, 260, 256);
        tmr(0, 0, 0, 0, 300, 0);
        cfg(1'b0, 6'h10, 4'h0, 32'h0000_0000);
        chk("zero limit", 32'h0000_0100, rd);
    endtask

    // Main sequence.
    initial begin
        sys_rst         = 1'b1;
        mst_phase_start = 1'b0;
        mst_phase_end   = 1'b0;
        mst_trdy_seen   = 1'b0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_regs();
        t_timer();
        end_sim();
    end
endmodule
